// [src/pm_pkg.sv]
// Operation
// - writing a low-power device state starts link entry to L1, or L2/L3 for D3
// - power capability sits at 48h, express capability with link controls at 70h
// - secondary bus clock runs only in D0, gated off in D1, D2, D3
// - reference clock needed in D0-D2; in D3 it may be present or removed
// - in D0 the link enters L0s/L1 only with nothing pending and transmitter idle long enough
// - link control field picks L0s only, L1 only, or both
// - link capabilities report L0s and L1 exit latencies read-only
// - sticky bits reset only by global reset pin or power-on reset
// - fundamental-class bits reset by PERST, global reset pin or power-on reset
// - other bits reset by hot reset, PERST, global reset pin or power-on reset
// - configuration space uses the type 1 bridge header layout
package pm_pkg;

  // ****************************************
  // configuration offsets
  // ****************************************
  localparam logic [11:0] HEADER_TYPE_OFS   = 12'h00c;
  localparam logic [11:0] PM_CAP_HDR_OFS    = 12'h048;
  localparam logic [11:0] PM_CSR_OFS        = 12'h04c;
  localparam logic [11:0] EXP_CAP_HDR_OFS   = 12'h070;
  localparam logic [11:0] DEV_CAP_OFS       = 12'h074;
  localparam logic [11:0] DEV_CTL_OFS       = 12'h078;
  localparam logic [11:0] LINK_CAP_OFS      = 12'h07c;
  localparam logic [11:0] LINK_CTL_OFS      = 12'h080;

  // ****************************************
  // field layouts and fixed values
  // ****************************************
  localparam logic [7:0]  HEADER_TYPE_BRIDGE = 8'h01;
  localparam int unsigned HEADER_TYPE_POS    = 16;
  localparam logic [7:0]  POWER_MGMT_CAPABILITY_HEADER          = 8'h01;
  localparam logic [7:0]  PM_NEXT_PTR        = 8'h50;
  localparam logic [7:0]  EXP_CAP_ID         = 8'h10;
  localparam logic [7:0]  EXP_NEXT_PTR       = 8'h00;
  localparam int unsigned PME_EN_POS         = 8;
  localparam int unsigned BSE_POS            = 16;
  localparam logic [14:0] DEV_CTL_HOT_MASK   = 15'h0fff;
  localparam logic [14:0] DEV_CTL_FUND_MASK  = 15'h7000;
  localparam logic [7:0]  LINK_CTL_MASK      = 8'hc3;
  localparam int unsigned ASPM_SUP_POS       = 10;
  localparam int unsigned L0S_LAT_POS        = 12;
  localparam int unsigned L1_LAT_POS         = 15;
  localparam logic [9:0]  LINK_CAP_LOW       = 10'h011;
  localparam logic [1:0]  ASPM_SUPPORT_BOTH  = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned L0S_IDLE_NS   = 7000;
  localparam int unsigned L1_IDLE_NS    = 10000;
  localparam int unsigned L0S_IDLE_CYC  = (L0S_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned L1_IDLE_CYC   = (L1_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CNT_W    = 8;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    D0 = 2'b00,
    D1 = 2'b01,
    D2 = 2'b10,
    D3 = 2'b11
  } d_state_t;

  typedef enum logic [1:0] {
    ASPM_OFF  = 2'b00,
    ASPM_L0S  = 2'b01,
    ASPM_L1   = 2'b10,
    ASPM_BOTH = 2'b11
  } aspm_sel_t;

  typedef enum logic [1:0] {
    LINK_L0   = 2'b00,
    LINK_L0S  = 2'b01,
    LINK_L1   = 2'b10,
    LINK_L2L3 = 2'b11
  } link_state_t;

endpackage

// [src/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned      WIDTH     = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;

  // ****************************************
  // accept a change once stages two and three agree
  // ****************************************
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q  <= RESET_VAL;
      s2_q  <= RESET_VAL;
      s3_q  <= RESET_VAL;
      lvl_q <= RESET_VAL;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign pin_level = lvl_q;

endmodule

// [src/bridge_power_state_control.sv]
`timescale 1ns/1ps
module bridge_power_state_control
  import pm_pkg::*;
#(
  parameter logic [IDLE_CNT_W-1:0] L0S_IDLE_CYCLES = IDLE_CNT_W'(pm_pkg::L0S_IDLE_CYC),
  parameter logic [IDLE_CNT_W-1:0] L1_IDLE_CYCLES  = IDLE_CNT_W'(pm_pkg::L1_IDLE_CYC),
  parameter logic [2:0]            L0S_EXIT_LAT    = 3'h3,
  parameter logic [2:0]            L1_EXIT_LAT     = 3'h2,
  parameter logic [15:0]           PM_CAPS         = 16'h0603,
  parameter logic [7:0]            BSE_VALUE       = 8'h00,
  parameter logic [15:0]           EXP_CAPS        = 16'h0072,
  parameter logic [31:0]           DEV_CAPS        = 32'h0000_0000
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 global_reset_pin_n,
  input  wire logic                 perst_n,
  input  wire logic                 hot_reset,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [11:0]          cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  output logic                      cfg_rd_valid,
  input  wire logic                 tx_pending,
  input  wire logic                 tx_idle,
  output pm_pkg::link_state_t       link_state,
  output pm_pkg::d_state_t          d_state,
  output logic                      sec_clk_enable,
  output logic                      ref_clk_needed
);

  import pm_pkg::*;

  // ****************************************
  // reset classes
  // ****************************************
  logic [1:0] pins_sync;
  logic       rst_sticky;
  logic       rst_fund;
  logic       rst_hot;

  pin_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) pin_sync_inst (
    .clk       (clk),
    .reset     (reset),
    .pin_in    ({global_reset_pin_n, perst_n}),
    .pin_level (pins_sync)
  );

  always_comb begin
    rst_sticky = reset | ~pins_sync[1];
    rst_fund   = rst_sticky | ~pins_sync[0];
    rst_hot    = rst_fund | hot_reset;
  end

  // ****************************************
  // configuration registers
  // ****************************************
  d_state_t    pwr_state_q;
  d_state_t    pwr_state_d;
  logic        pme_en_q;
  logic        pme_en_d;
  logic [14:0] dev_ctl_hot_q;
  logic [14:0] dev_ctl_hot_d;
  logic [14:0] dev_ctl_fund_q;
  logic [14:0] dev_ctl_fund_d;
  logic [7:0]  link_ctl_q;
  logic [7:0]  link_ctl_d;
  logic [31:0] wmask;
  logic [31:0] cur_word;
  logic [31:0] merged;
  logic [31:0] link_cap_word;
  aspm_sel_t   aspm_sel;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{cfg_be[b]}};
    end
    link_cap_word = {14'h0000, L1_EXIT_LAT, L0S_EXIT_LAT, ASPM_SUPPORT_BOTH, LINK_CAP_LOW};
    unique case (cfg_addr)
      PM_CAP_HDR_OFS:  cur_word = {PM_CAPS, PM_NEXT_PTR, POWER_MGMT_CAPABILITY_HEADER};
      PM_CSR_OFS:      cur_word = {8'h00, BSE_VALUE, 7'h00, pme_en_q, 6'h00, pwr_state_q};
      EXP_CAP_HDR_OFS: cur_word = {EXP_CAPS, EXP_NEXT_PTR, EXP_CAP_ID};
      DEV_CAP_OFS:     cur_word = DEV_CAPS;
      DEV_CTL_OFS:     cur_word = {17'h00000, dev_ctl_hot_q | dev_ctl_fund_q};
      LINK_CAP_OFS:    cur_word = link_cap_word;
      LINK_CTL_OFS:    cur_word = {24'h000000, link_ctl_q};
      HEADER_TYPE_OFS: cur_word = {8'h00, HEADER_TYPE_BRIDGE, 16'h0000};
      default:         cur_word = 32'h0000_0000;
    endcase
    merged = (cur_word & ~wmask) | (cfg_wdata & wmask);
  end

  always_comb begin
    aspm_sel       = aspm_sel_t'(link_ctl_q[1:0]);
    pwr_state_d    = pwr_state_q;
    pme_en_d       = pme_en_q;
    dev_ctl_hot_d  = dev_ctl_hot_q;
    dev_ctl_fund_d = dev_ctl_fund_q;
    link_ctl_d     = link_ctl_q;
    if (cfg_wr) begin
      unique case (cfg_addr)
        PM_CSR_OFS: begin
          pwr_state_d = d_state_t'(merged[1:0]);
          pme_en_d    = merged[PME_EN_POS];
        end
        DEV_CTL_OFS: begin
          dev_ctl_hot_d  = merged[14:0] & DEV_CTL_HOT_MASK;
          dev_ctl_fund_d = merged[14:0] & DEV_CTL_FUND_MASK;
        end
        LINK_CTL_OFS: begin
          link_ctl_d = merged[7:0] & LINK_CTL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst_sticky) begin
      pme_en_q <= 1'b0;
    end else begin
      pme_en_q <= pme_en_d;
    end
    if (rst_fund) begin
      dev_ctl_fund_q <= 15'h0000;
    end else begin
      dev_ctl_fund_q <= dev_ctl_fund_d;
    end
    if (rst_hot) begin
      pwr_state_q   <= D0;
      dev_ctl_hot_q <= 15'h0000;
      link_ctl_q    <= 8'h00;
    end else begin
      pwr_state_q   <= pwr_state_d;
      dev_ctl_hot_q <= dev_ctl_hot_d;
      link_ctl_q    <= link_ctl_d;
    end
  end

  // ****************************************
  // read answer, one cycle after the request
  // ****************************************
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;

  always_comb begin
    rvalid_d = cfg_rd;
    rdata_d  = cfg_rd ? cur_word : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (rst_hot) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************
  // link power state machine
  // ****************************************
  link_state_t           link_q;
  link_state_t           link_d;
  logic [IDLE_CNT_W-1:0] idle_cnt_q;
  logic [IDLE_CNT_W-1:0] idle_cnt_d;
  logic                  busy;
  logic                  l0s_ok;
  logic                  l1_ok;
  logic                  aspm_l0s;
  logic                  aspm_l1;
  link_state_t           sw_target;

  always_comb begin
    busy      = tx_pending | ~tx_idle;
    l0s_ok    = ~busy && (idle_cnt_q >= L0S_IDLE_CYCLES);
    l1_ok     = ~busy && (idle_cnt_q >= L1_IDLE_CYCLES);
    aspm_l0s  = (aspm_sel == ASPM_L0S) || (aspm_sel == ASPM_BOTH);
    aspm_l1   = (aspm_sel == ASPM_L1) || (aspm_sel == ASPM_BOTH);
    sw_target = (pwr_state_q == D3) ? LINK_L2L3 : LINK_L1;
    link_d    = link_q;
    unique case (link_q)
      LINK_L0: begin
        if (pwr_state_q != D0) begin
          link_d = sw_target;
        end else if (aspm_l0s && l0s_ok) begin
          link_d = LINK_L0S;
        end else if (aspm_l1 && !aspm_l0s && l1_ok) begin
          link_d = LINK_L1;
        end
      end
      LINK_L0S: begin
        if (pwr_state_q != D0) begin
          link_d = sw_target;
        end else if (busy || !aspm_l0s) begin
          link_d = LINK_L0;
        end else if (aspm_l1 && l1_ok) begin
          link_d = LINK_L1;
        end
      end
      LINK_L1: begin
        if (pwr_state_q == D3) begin
          link_d = LINK_L2L3;
        end else if (pwr_state_q == D0 && (busy || !aspm_l1)) begin
          link_d = LINK_L0;
        end
      end
      LINK_L2L3: begin
        link_d = LINK_L2L3;
      end
    endcase
    if (busy || link_d == LINK_L1 || link_d == LINK_L2L3) begin
      idle_cnt_d = '0;
    end else if (idle_cnt_q != '1) begin
      idle_cnt_d = idle_cnt_q + IDLE_CNT_W'(1);
    end else begin
      idle_cnt_d = idle_cnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_hot) begin
      link_q     <= LINK_L0;
      idle_cnt_q <= '0;
    end else begin
      link_q     <= link_d;
      idle_cnt_q <= idle_cnt_d;
    end
  end

  // ****************************************
  // clock control outputs
  // ****************************************
  logic sec_clk_q;
  logic sec_clk_d;
  logic ref_need_q;
  logic ref_need_d;

  always_comb begin
    sec_clk_d  = (pwr_state_d == D0);
    ref_need_d = (pwr_state_d != D3);
  end

  always_ff @(posedge clk) begin
    if (rst_hot) begin
      sec_clk_q  <= 1'b1;
      ref_need_q <= 1'b1;
    end else begin
      sec_clk_q  <= sec_clk_d;
      ref_need_q <= ref_need_d;
    end
  end

  assign cfg_rdata      = rdata_q;
  assign cfg_rd_valid   = rvalid_q;
  assign link_state     = link_q;
  assign d_state        = pwr_state_q;
  assign sec_clk_enable = sec_clk_q;
  assign ref_clk_needed = ref_need_q;

endmodule

// [testbench/bridge_power_state_control_monitor.sv]
`timescale 1ns/1ps
module bridge_power_state_control_monitor
  import pm_pkg::*;
#(
  parameter logic [IDLE_CNT_W-1:0] L0S_IDLE_CYCLES = IDLE_CNT_W'(pm_pkg::L0S_IDLE_CYC),
  parameter logic [IDLE_CNT_W-1:0] L1_IDLE_CYCLES  = IDLE_CNT_W'(pm_pkg::L1_IDLE_CYC)
) (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          hot_reset,
  input wire logic          cfg_rd,
  input wire logic [11:0]   cfg_addr,
  input wire logic [31:0]   cfg_rdata,
  input wire logic          cfg_rd_valid,
  input wire logic          tx_pending,
  input wire logic          tx_idle,
  input pm_pkg::link_state_t link_state,
  input pm_pkg::d_state_t   d_state,
  input wire logic          sec_clk_enable,
  input wire logic          ref_clk_needed
);
  // ****
  // idle streak, never below the design's counter
  // ****
  int   idle_q;
  int   idle_d;
  logic busy;
  assign busy = tx_pending || !tx_idle;
  always_comb begin
    idle_d = busy ? 0 : idle_q + 1;
  end
  always_ff @(posedge clk) begin
    idle_q <= reset ? 0 : idle_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_to_l0s;
    link_state == LINK_L0 ##1 link_state == LINK_L0S;
  endsequence
  sequence s_aspm_l1;
    d_state == D0 && link_state inside {LINK_L0, LINK_L0S} ##1 link_state == LINK_L1;
  endsequence
  a_clk_gate: assert property (sec_clk_enable == (d_state == D0))
    else $error("secondary clock gate wrong");
  a_ref_clk: assert property (ref_clk_needed == (d_state != D3))
    else $error("reference clock need wrong");
  a_pm_cap: assert property (cfg_rd && !hot_reset && cfg_addr == PM_CAP_HDR_OFS
    |=> cfg_rd_valid && cfg_rdata[7:0] == POWER_MGMT_CAPABILITY_HEADER) else $error("power capability read wrong");
  a_bridge_hdr: assert property (cfg_rd && !hot_reset && cfg_addr == HEADER_TYPE_OFS
    |=> cfg_rdata[23:16] == HEADER_TYPE_BRIDGE) else $error("header type wrong");
  a_deep_link: assert property ($changed(d_state) && d_state == D3 && !hot_reset
    |=> link_state == LINK_L2L3) else $error("no deep link entry");
  a_mid_link: assert property ($changed(d_state) && d_state inside {D1, D2} && !hot_reset
    |=> link_state == LINK_L1) else $error("no link L1 entry");
  a_l0s_entry: assert property (s_to_l0s |-> $past(idle_q) >= L0S_IDLE_CYCLES)
    else $error("L0s entered too early");
  a_l1_entry: assert property (s_aspm_l1 |-> $past(idle_q) >= L1_IDLE_CYCLES)
    else $error("L1 entered too early");
  a_busy_exit: assert property (link_state == LINK_L0S && busy && d_state == D0 && !hot_reset
    |=> link_state == LINK_L0) else $error("busy link left in L0s");
endmodule

// [testbench/link_partner.sv]
`timescale 1ns/1ps
module link_partner (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic traffic,
  output logic      tx_pending,
  output logic      tx_idle
);
  // ****
  // transmitter drains a short tail after traffic stops
  // ****
  logic [1:0] tail_q;
  logic [1:0] tail_d;
  always_comb begin
    tail_d = traffic ? 2'h3 : (tail_q != 2'h0 ? tail_q - 2'h1 : 2'h0);
  end
  always_ff @(posedge clk) begin
    tail_q <= reset ? 2'h3 : tail_d;
  end
  assign tx_pending = traffic;
  assign tx_idle    = (tail_q == 2'h0);
endmodule

// [testbench/bridge_power_state_control_test.sv]
`timescale 1ns/1ps
module bridge_power_state_control_test;
  import pm_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, global_reset_pin_n = 1'b1, perst_n = 1'b1;
  logic        hot_reset = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, traffic = 1'b1;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rd_q;
  logic        cfg_rd_valid, tx_pending, tx_idle, sec_clk_enable, ref_clk_needed;
  link_state_t link_state;
  d_state_t    d_state;
  int          n_errors = 0, tests_run = 0;
  always #50 clk = ~clk;
  bridge_power_state_control #(.L0S_IDLE_CYCLES(8'h03), .L1_IDLE_CYCLES(8'h05)) bridge_power_state_control_inst (
    .clk(clk), .reset(reset), .global_reset_pin_n(global_reset_pin_n), .perst_n(perst_n),
    .hot_reset(hot_reset), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .tx_pending(tx_pending),
    .tx_idle(tx_idle), .link_state(link_state), .d_state(d_state), .sec_clk_enable(sec_clk_enable),
    .ref_clk_needed(ref_clk_needed));
  link_partner link_partner_inst (.clk(clk), .reset(reset), .traffic(traffic), .tx_pending(tx_pending),
    .tx_idle(tx_idle));
  // ****
  // bus cycles and checking
  // ****
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    {cfg_addr, cfg_be, cfg_wdata, cfg_wr} = {a, be, d, 1'b1};
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic cfg_read(input logic [11:0] a);
    @(negedge clk);
    {cfg_addr, cfg_rd} = {a, 1'b1};
    @(negedge clk);
    cfg_rd = 1'b0;
    rd_q = cfg_rdata;
    chk("rd_valid", 32'(cfg_rd_valid), 32'h1);
  endtask
  task automatic pulse(input int which);
    @(negedge clk);
    case (which)
      0: hot_reset = 1'b1;
      1: perst_n = 1'b0;
      default: global_reset_pin_n = 1'b0;
    endcase
    repeat (10) @(negedge clk);
    {hot_reset, perst_n, global_reset_pin_n} = 3'b011;
    repeat (10) @(negedge clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    cfg_read(HEADER_TYPE_OFS);
    chk("hdr_type", 32'(rd_q[23:16]), 32'(HEADER_TYPE_BRIDGE));
    cfg_read(PM_CAP_HDR_OFS);
    chk("pm_cap", rd_q, {16'h0603, PM_NEXT_PTR, POWER_MGMT_CAPABILITY_HEADER});
    cfg_read(EXP_CAP_HDR_OFS);
    chk("exp_cap", rd_q, {16'h0072, EXP_NEXT_PTR, EXP_CAP_ID});
    cfg_write(LINK_CAP_OFS, 4'hf, 32'hffff_ffff);
    cfg_read(LINK_CAP_OFS);
    chk("link_cap", 32'(rd_q[17:10]), 32'({3'h2, 3'h3, ASPM_SUPPORT_BOTH}));
    cfg_read(12'h04d);
    chk("misaligned", rd_q, 32'h0);
    cfg_read(12'h200);
    chk("unmapped", rd_q, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_dstate;
    for (int i = 1; i < 4; i++) begin
      cfg_write(PM_CSR_OFS, 4'h1, 32'(i));
      @(negedge clk);
      chk("d_state", 32'(d_state), 32'(i));
      chk("sec_clk", 32'(sec_clk_enable), 32'h0);
      chk("ref_clk", 32'(ref_clk_needed), 32'(i != 3));
      chk("link", 32'(link_state), 32'(i == 3 ? LINK_L2L3 : LINK_L1));
      cfg_read(PM_CSR_OFS);
      chk("pstate", 32'(rd_q[1:0]), 32'(i));
      if (i < 3) begin
        cfg_write(PM_CSR_OFS, 4'h1, 32'h0);
        chk("sec_clk_d0", 32'(sec_clk_enable), 32'h1);
      end
    end
    @(negedge clk);
    hot_reset = 1'b1;
    @(negedge clk);
    hot_reset = 1'b0;
    chk("hot_d", 32'({d_state, link_state, sec_clk_enable, ref_clk_needed}), 32'h3);
    $display("t_dstate done");
  endtask
  task automatic t_aspm;
    link_state_t exp_l[4] = '{LINK_L0, LINK_L0S, LINK_L1, LINK_L1};
    for (int m = 0; m < 4; m++) begin
      traffic = 1'b1;
      cfg_write(LINK_CTL_OFS, 4'h1, 32'(m));
      repeat (20) @(negedge clk);
      chk("busy_link", 32'(link_state), 32'(LINK_L0));
      cfg_read(LINK_CTL_OFS);
      chk("aspm_sel", 32'(rd_q[1:0]), 32'(m));
      traffic = 1'b0;
      repeat (20) @(negedge clk);
      chk("idle_link", 32'(link_state), 32'(exp_l[m]));
      traffic = 1'b1;
      repeat (3) @(negedge clk);
      chk("wake_link", 32'(link_state), 32'(LINK_L0));
    end
    $display("t_aspm done");
  endtask
  task automatic t_classes;
    cfg_write(PM_CSR_OFS, 4'h2, 32'h100);
    cfg_write(DEV_CTL_OFS, 4'h3, 32'h7fff);
    pulse(0);
    cfg_read(DEV_CTL_OFS);
    chk("dev_ctl_hot", 32'(rd_q[14:0]), 32'(DEV_CTL_FUND_MASK));
    pulse(1);
    cfg_read(DEV_CTL_OFS);
    chk("dev_ctl_perst", 32'(rd_q[14:0]), 32'h0);
    cfg_read(PM_CSR_OFS);
    chk("pme_kept", 32'(rd_q[8]), 32'h1);
    pulse(2);
    cfg_read(PM_CSR_OFS);
    chk("pme_cleared", 32'(rd_q[8]), 32'h0);
    $display("t_classes done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    t_regs;
    t_dstate;
    t_aspm;
    t_classes;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
endmodule
bind bridge_power_state_control bridge_power_state_control_monitor #(.L0S_IDLE_CYCLES(L0S_IDLE_CYCLES),
  .L1_IDLE_CYCLES(L1_IDLE_CYCLES)) mon_inst (.clk(clk), .reset(reset), .hot_reset(hot_reset),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
  .tx_pending(tx_pending), .tx_idle(tx_idle), .link_state(link_state), .d_state(d_state),
  .sec_clk_enable(sec_clk_enable), .ref_clk_needed(ref_clk_needed));
